// *** cdr_core.sv ***
// dedicated register set and condition flags of the 8-bit cpu
`timescale 1ns/1ns
module cdr_core
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire cdr_pkg::cdr_op_t op_in,
  input wire logic byte_in,
  input wire logic sub_in,
  input wire logic shift_right_in,
  input wire logic [2:0] sel_in,
  input wire logic [15:0] data_in,
  input wire logic [7:0] disp_in,
  input wire logic iptr_inc_in,
  input wire logic irq_req_in,
  input wire logic [1:0] irq_level_in,
  output logic [15:0] iptr_out,
  output logic [15:0] acc_out,
  output logic [15:0] aux_out,
  output logic [15:0] idx_out,
  output logic [15:0] xptr_out,
  output logic [15:0] stack_out,
  output logic [15:0] status_out,
  output logic [15:0] index_addr_out,
  output logic irq_accept_out
);

  // ==========================================================
  // registers
  logic [15:0] iptr_r, iptr_nxt;
  logic [15:0] a_r, a_nxt;
  logic [15:0] t_r, t_nxt;
  logic [15:0] idx_r, idx_nxt;
  logic [15:0] xptr_r, xptr_nxt;
  logic [15:0] stk_r, stk_nxt;
  logic [7:0] bank_r, bank_nxt;
  logic [7:0] flags_r, flags_nxt;

  // ==========================================================
  // arithmetic: subtraction adds the inverted aux plus one
  wire [7:0] alu_b_lo = sub_in ? ~t_r[7:0] : t_r[7:0];
  wire [15:0] alu_b_w = sub_in ? ~t_r : t_r;
  wire [8:0] sum_lo = {1'b0, a_r[7:0]} + {1'b0, alu_b_lo} + {8'h00, sub_in};
  wire [16:0] sum_w = {1'b0, a_r} + {1'b0, alu_b_w} + {16'h0000, sub_in};
  wire [15:0] alu_res = byte_in ? {a_r[15:8], sum_lo[7:0]} : sum_w[15:0];
  // borrow is the inverted adder carry
  // half-carry comes from the low nibble for word ops too, for decimal adjust
  wire alu_h = (a_r[4] ^ alu_b_lo[4] ^ sum_lo[4]) ^ sub_in;
  wire alu_c = (byte_in ? sum_lo[8] : sum_w[16]) ^ sub_in;
  wire alu_n = byte_in ? sum_lo[7] : sum_w[15];
  wire alu_z = byte_in ? (sum_lo[7:0] == 8'h00) : (sum_w[15:0] == 16'h0000);
  wire a_msb = byte_in ? a_r[7] : a_r[15];
  wire b_msb = byte_in ? alu_b_lo[7] : alu_b_w[15];
  wire alu_v = (a_msb == b_msb) && (alu_n != a_msb);

  // ==========================================================
  // shift through carry
  wire c_old = flags_r[cdr_pkg::FLG_C];
  wire sh_out = shift_right_in ? a_r[0] : (byte_in ? a_r[7] : a_r[15]);
  wire [7:0] sh_b = shift_right_in ? {c_old, a_r[7:1]} : {a_r[6:0], c_old};
  wire [15:0] sh_w = shift_right_in ? {c_old, a_r[15:1]} : {a_r[14:0], c_old};
  wire [15:0] sh_res = byte_in ? {a_r[15:8], sh_b} : sh_w;

  // ==========================================================
  // accumulator loads; reading the status word is always a word move
  wire ld_byte = byte_in && (op_in == cdr_pkg::OP_LOAD_A);
  wire [15:0] status_word = {bank_r, flags_r};
  wire [15:0] ld_src = (op_in == cdr_pkg::OP_RD_STATUS) ? status_word : data_in;
  wire [15:0] ld_acc = ld_byte ? {a_r[15:8], ld_src[7:0]} : ld_src;
  wire [15:0] ld_aux = ld_byte ? {t_r[15:8], a_r[7:0]} : a_r;

  // ==========================================================
  // interrupt gate; request comes from logic on the same clock
  wire [1:0] cur_level = {flags_r[cdr_pkg::FLG_PRIO_HI], flags_r[cdr_pkg::FLG_PRIO_LO]};
  wire irq_ok = irq_req_in && flags_r[cdr_pkg::FLG_I] && (irq_level_in < cur_level);

  // ==========================================================
  // next-state decode
  always_comb
  begin
    iptr_nxt = iptr_r;
    a_nxt = a_r;
    t_nxt = t_r;
    idx_nxt = idx_r;
    xptr_nxt = xptr_r;
    stk_nxt = stk_r;
    bank_nxt = bank_r;
    flags_nxt = flags_r;
    if (iptr_inc_in)
    begin
      iptr_nxt = iptr_r + 16'h0001;
    end
    unique case (op_in)
      cdr_pkg::OP_NOP:
      begin
        flags_nxt = flags_r;
      end
      cdr_pkg::OP_LOAD_A, cdr_pkg::OP_RD_STATUS:
      begin
        a_nxt = ld_acc;
        t_nxt = ld_aux;
      end
      cdr_pkg::OP_ALU:
      begin
        a_nxt = alu_res;
        flags_nxt[cdr_pkg::FLG_H] = alu_h;
        flags_nxt[cdr_pkg::FLG_N] = alu_n;
        flags_nxt[cdr_pkg::FLG_Z] = alu_z;
        flags_nxt[cdr_pkg::FLG_V] = alu_v;
        flags_nxt[cdr_pkg::FLG_C] = alu_c;
      end
      cdr_pkg::OP_SHIFT:
      begin
        a_nxt = sh_res;
        flags_nxt[cdr_pkg::FLG_C] = sh_out;
      end
      cdr_pkg::OP_WR_REG:
      begin
        unique case (sel_in)
          cdr_pkg::SEL_AUX: t_nxt = data_in;
          cdr_pkg::SEL_IDX: idx_nxt = data_in;
          cdr_pkg::SEL_XPTR: xptr_nxt = data_in;
          cdr_pkg::SEL_STACK: stk_nxt = data_in;
          cdr_pkg::SEL_IPTR: iptr_nxt = data_in;
          default: t_nxt = t_r;
        endcase
      end
      cdr_pkg::OP_WR_STATUS:
      begin
        bank_nxt = a_r[15:8];
        flags_nxt = a_r[7:0];
      end
      cdr_pkg::OP_SET_LVL:
      begin
        flags_nxt[cdr_pkg::FLG_PRIO_HI] = irq_level_in[1];
        flags_nxt[cdr_pkg::FLG_PRIO_LO] = irq_level_in[0];
      end
      default:
      begin
        flags_nxt = flags_r;
      end
    endcase
  end

  // ==========================================================
  // state; undefined reset values are fixed at zero for determinism
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      iptr_r <= cdr_pkg::IPTR_RESET;
      a_r <= cdr_pkg::GP_RESET;
      t_r <= cdr_pkg::GP_RESET;
      idx_r <= cdr_pkg::GP_RESET;
      xptr_r <= cdr_pkg::GP_RESET;
      stk_r <= cdr_pkg::GP_RESET;
      bank_r <= cdr_pkg::BANK_RESET;
      flags_r <= cdr_pkg::FLAGS_RESET;
    end
    else if (ce_in)
    begin
      iptr_r <= iptr_nxt;
      a_r <= a_nxt;
      t_r <= t_nxt;
      idx_r <= idx_nxt;
      xptr_r <= xptr_nxt;
      stk_r <= stk_nxt;
      bank_r <= bank_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign iptr_out = iptr_r;
  assign acc_out = a_r;
  assign aux_out = t_r;
  assign idx_out = idx_r;
  assign xptr_out = xptr_r;
  assign stack_out = stk_r;
  assign status_out = status_word;
  // combinational so an indexed access needs no extra cycle
  assign index_addr_out = idx_r + {{8{disp_in[7]}}, disp_in};
  assign irq_accept_out = irq_ok;

  // ==========================================================
  // checks
  // expected values are worked out from the operands, not from the alu wiring
  a_iptr_reset: assert property (
    @(posedge ref_clk_in) !nrst_in |=> iptr_out == cdr_pkg::IPTR_RESET)
    else $error("instruction pointer wrong after reset");

  a_flags_reset: assert property (
    @(posedge ref_clk_in) !nrst_in |=> status_out[6:4] == 3'h3)
    else $error("enable or level bits wrong after reset");

  a_acc_high_kept: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && (op_in == cdr_pkg::OP_LOAD_A || op_in == cdr_pkg::OP_ALU)
    |=> acc_out[15:8] == $past(acc_out[15:8]))
    else $error("byte op changed accumulator high byte");

  a_aux_copy_word: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && !byte_in && op_in == cdr_pkg::OP_LOAD_A
    |=> aux_out == $past(acc_out) && acc_out == $past(data_in))
    else $error("word load did not copy accumulator to aux");

  a_aux_copy_byte: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && op_in == cdr_pkg::OP_LOAD_A
    |=> aux_out == {$past(aux_out[15:8]), $past(acc_out[7:0])})
    else $error("byte load copy wrong in aux");

  a_status_round_trip: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && op_in == cdr_pkg::OP_WR_STATUS ##1 ce_in && op_in == cdr_pkg::OP_RD_STATUS
    |=> acc_out == $past(acc_out, 2))
    else $error("status word round trip lost bits");

  a_zero_neg_flags: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && op_in == cdr_pkg::OP_ALU
    |=> status_out[2] == (acc_out[7:0] == 8'h00) && status_out[3] == acc_out[7])
    else $error("zero or negative flag disagrees with result");

  a_byte_carry: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && !sub_in && op_in == cdr_pkg::OP_ALU
    |=> status_out[0] == ({1'b0, $past(acc_out[7:0])} + {1'b0, $past(aux_out[7:0])} > 9'h0ff))
    else $error("byte add carry wrong");

  a_shift_carry: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && !shift_right_in && op_in == cdr_pkg::OP_SHIFT
    |=> status_out[0] == $past(acc_out[7]) && acc_out[0] == $past(status_out[0]))
    else $error("shift did not move bit into carry");

  a_irq_gate: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    irq_accept_out |-> status_out[6] && irq_level_in < status_out[5:4])
    else $error("interrupt accepted while gated");

  a_flags_hold: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && (op_in == cdr_pkg::OP_LOAD_A || op_in == cdr_pkg::OP_WR_REG)
    |=> status_out == $past(status_out))
    else $error("flags changed by op without flag effect");

  a_word_carry: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && !byte_in && !sub_in && op_in == cdr_pkg::OP_ALU
    |=> status_out[0] == ({1'b0, $past(acc_out)} + {1'b0, $past(aux_out)} > 17'h0ffff))
    else $error("word add carry wrong");

  a_half_carry: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && !sub_in && op_in == cdr_pkg::OP_ALU
    |=> status_out[7] == ({1'b0, $past(acc_out[3:0])} + {1'b0, $past(aux_out[3:0])} > 5'h0f))
    else $error("half-carry wrong on add");

  a_byte_borrow: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && sub_in && op_in == cdr_pkg::OP_ALU
    |=> status_out[0] == ($past(acc_out[7:0]) < $past(aux_out[7:0])))
    else $error("byte subtract borrow wrong");

  a_byte_overflow: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && !sub_in && op_in == cdr_pkg::OP_ALU
    |=> status_out[1] == ($past(acc_out[7]) == $past(aux_out[7]) && acc_out[7] != $past(acc_out[7])))
    else $error("byte add overflow wrong");

  a_shift_right: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && byte_in && shift_right_in && op_in == cdr_pkg::OP_SHIFT
    |=> status_out[0] == $past(acc_out[0]) && acc_out[7] == $past(status_out[0]))
    else $error("right shift did not move bit into carry");

  a_stack_write: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && op_in == cdr_pkg::OP_WR_REG && sel_in == cdr_pkg::SEL_STACK
    |=> stack_out == $past(data_in))
    else $error("stack pointer write lost");

  a_iptr_step: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && iptr_inc_in && op_in != cdr_pkg::OP_WR_REG
    |=> iptr_out == $past(iptr_out) + 16'h0001)
    else $error("instruction pointer did not step");

  a_bank_hold: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !(ce_in && op_in == cdr_pkg::OP_WR_STATUS)
    |=> status_out[15:8] == $past(status_out[15:8]))
    else $error("bank selector changed outside a status write");

  // a frozen cycle must not leak a half-applied command
  a_ce_freeze: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !ce_in
    |=> acc_out == $past(acc_out) && aux_out == $past(aux_out) && iptr_out == $past(iptr_out))
    else $error("state moved while clock enable low");

  c_byte_add_carry: cover property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && op_in == cdr_pkg::OP_ALU && byte_in ##1 status_out[0]);

  c_status_write: cover property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && op_in == cdr_pkg::OP_WR_STATUS);

  c_word_sub: cover property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && op_in == cdr_pkg::OP_ALU && !byte_in && sub_in);

  c_shift_right: cover property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    ce_in && op_in == cdr_pkg::OP_SHIFT && shift_right_in);

  c_irq_accept: cover property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    irq_accept_out);

endmodule

// *** cdr_pkg.sv ***
// constants and command codes for the cpu dedicated register set
package cdr_pkg;
  // ==========================================================
  // reset values
  localparam logic [15:0] IPTR_RESET = 16'hfffd;
  localparam logic [15:0] GP_RESET = 16'h0000;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h30;
  // ==========================================================
  // condition flags byte bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_PRIO_LO = 4;
  localparam int FLG_PRIO_HI = 5;
  localparam int FLG_I = 6;
  localparam int FLG_H = 7;
  // ==========================================================
  // destination select for register writes
  localparam logic [2:0] SEL_AUX = 3'h0;
  localparam logic [2:0] SEL_IDX = 3'h1;
  localparam logic [2:0] SEL_XPTR = 3'h2;
  localparam logic [2:0] SEL_STACK = 3'h3;
  localparam logic [2:0] SEL_IPTR = 3'h4;
  // ==========================================================
  // instruction-level commands from the sequencer
  typedef enum logic [7:0] {
    OP_NOP = 8'h01,
    OP_LOAD_A = 8'h02,
    OP_ALU = 8'h04,
    OP_SHIFT = 8'h08,
    OP_WR_REG = 8'h10,
    OP_WR_STATUS = 8'h20,
    OP_RD_STATUS = 8'h40,
    OP_SET_LVL = 8'h80
  } cdr_op_t;
endpackage

// *** tb_cdr_core.sv ***
// self-checking bench for the cpu dedicated register set
`timescale 1ns/1ns
module tb_cdr_core;
  // ==========================================================
  // stimulus and observed signals
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  cdr_pkg::cdr_op_t op_in = cdr_pkg::OP_NOP;
  logic byte_in = 1'b0;
  logic sub_in = 1'b0;
  logic shift_right_in = 1'b0;
  logic [2:0] sel_in = 3'h0;
  logic [15:0] data_in = 16'h0000;
  logic [7:0] disp_in = 8'h00;
  logic iptr_inc_in = 1'b0;
  // request pending from time zero so the gate is exercised while disabled
  logic irq_req_in = 1'b1;
  logic [1:0] irq_level_in = 2'h0;
  logic [15:0] iptr_out, acc_out, aux_out, idx_out, xptr_out, stack_out, status_out;
  logic [15:0] index_addr_out;
  logic irq_accept_out;
  int n_mismatch = 0;
  int compares = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  cdr_core DUT (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .op_in(op_in),
    .byte_in(byte_in),
    .sub_in(sub_in),
    .shift_right_in(shift_right_in),
    .sel_in(sel_in),
    .data_in(data_in),
    .disp_in(disp_in),
    .iptr_inc_in(iptr_inc_in),
    .irq_req_in(irq_req_in),
    .irq_level_in(irq_level_in),
    .iptr_out(iptr_out),
    .acc_out(acc_out),
    .aux_out(aux_out),
    .idx_out(idx_out),
    .xptr_out(xptr_out),
    .stack_out(stack_out),
    .status_out(status_out),
    .index_addr_out(index_addr_out),
    .irq_accept_out(irq_accept_out)
  );
  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one command, then a nop cycle so results are read before the next edge
  task automatic cmd(input cdr_pkg::cdr_op_t op, input logic bw, input logic sb,
                     input logic [2:0] s, input logic [15:0] d);
    @(negedge ref_clk_in);
    op_in = op;
    byte_in = bw;
    sub_in = sb;
    shift_right_in = sb;
    sel_in = s;
    data_in = d;
    @(negedge ref_clk_in);
    op_in = cdr_pkg::OP_NOP;
  endtask
  task automatic ld(input logic bw, input logic [15:0] d);
    cmd(cdr_pkg::OP_LOAD_A, bw, 1'b0, 3'h0, d);
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    cmd(cdr_pkg::OP_WR_REG, 1'b0, 1'b0, s, d);
  endtask
  // the gate is combinational: let it settle before sampling
  task automatic irq(input logic [1:0] lv, input logic exp);
    irq_level_in = lv;
    #1 chk("irq_accept", {15'h0000, irq_accept_out}, {15'h0000, exp});
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    chk("iptr", iptr_out, 16'hfffd);
    chk("status ctl", {13'h0000, status_out[6:4]}, 16'h0003);
    chk("irq_accept", {15'h0000, irq_accept_out}, 16'h0000);
    ld(1'b0, 16'h1234);
    chk("acc", acc_out, 16'h1234);
    ld(1'b0, 16'h5678);
    chk("aux", aux_out, 16'h1234);
    ld(1'b1, 16'h00ab);
    chk("acc", acc_out, 16'h56ab);
    chk("aux", aux_out, 16'h1278);
    // byte arithmetic with a junk aux high byte that must be ignored
    ld(1'b0, 16'h117f);
    wr(cdr_pkg::SEL_AUX, 16'hff01);
    cmd(cdr_pkg::OP_ALU, 1'b1, 1'b0, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'h1180);
    chk("status", status_out, 16'h00ba);
    cmd(cdr_pkg::OP_ALU, 1'b1, 1'b1, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'h117f);
    chk("status", status_out, 16'h00b2);
    wr(cdr_pkg::SEL_AUX, 16'h0081);
    cmd(cdr_pkg::OP_ALU, 1'b1, 1'b0, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'h1100);
    chk("status", status_out, 16'h00b5);
    cmd(cdr_pkg::OP_ALU, 1'b1, 1'b1, 3'h0, 16'h0000);
    chk("status", status_out, 16'h00b1);
    // word add: a byte add would give 7f00 here
    ld(1'b0, 16'h7fff);
    wr(cdr_pkg::SEL_AUX, 16'h0101);
    cmd(cdr_pkg::OP_ALU, 1'b0, 1'b0, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'h8100);
    chk("status", status_out, 16'h00ba);
    ld(1'b1, 16'h0080);
    cmd(cdr_pkg::OP_SHIFT, 1'b1, 1'b0, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'h8100);
    chk("status", status_out, 16'h00bb);
    cmd(cdr_pkg::OP_SHIFT, 1'b1, 1'b1, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'h8180);
    ld(1'b0, 16'ha570);
    chk("status", status_out, 16'h00ba);
    cmd(cdr_pkg::OP_WR_STATUS, 1'b0, 1'b0, 3'h0, 16'h0000);
    chk("status", status_out, 16'ha570);
    ld(1'b0, 16'h0000);
    cmd(cdr_pkg::OP_RD_STATUS, 1'b0, 1'b0, 3'h0, 16'h0000);
    chk("acc", acc_out, 16'ha570);
    chk("aux", aux_out, 16'h0000);
    // status write and read on adjacent edges
    @(negedge ref_clk_in);
    op_in = cdr_pkg::OP_WR_STATUS;
    @(negedge ref_clk_in);
    op_in = cdr_pkg::OP_RD_STATUS;
    @(negedge ref_clk_in);
    op_in = cdr_pkg::OP_NOP;
    chk("acc", acc_out, 16'ha570);
    irq(2'h3, 1'b0);
    irq(2'h1, 1'b1);
    cmd(cdr_pkg::OP_SET_LVL, 1'b0, 1'b0, 3'h0, 16'h0000);
    chk("status", status_out, 16'ha550);
    irq(2'h1, 1'b0);
    irq(2'h0, 1'b1);
    ld(1'b0, 16'h0030);
    cmd(cdr_pkg::OP_WR_STATUS, 1'b0, 1'b0, 3'h0, 16'h0000);
    irq(2'h0, 1'b0);
    wr(cdr_pkg::SEL_IDX, 16'h1000);
    disp_in = 8'h80;
    #1 chk("index_addr", index_addr_out, 16'h0f80);
    disp_in = 8'h7f;
    #1 chk("index_addr", index_addr_out, 16'h107f);
    wr(cdr_pkg::SEL_XPTR, 16'hbeef);
    chk("xptr", xptr_out, 16'hbeef);
    wr(cdr_pkg::SEL_STACK, 16'h01fe);
    chk("stack", stack_out, 16'h01fe);
    wr(3'h5, 16'h1111);
    chk("idx", idx_out, 16'h1000);
    wr(cdr_pkg::SEL_IPTR, 16'h0100);
    chk("iptr", iptr_out, 16'h0100);
    iptr_inc_in = 1'b1;
    @(negedge ref_clk_in);
    iptr_inc_in = 1'b0;
    chk("iptr", iptr_out, 16'h0101);
    // clock enable low must freeze everything
    ce_in = 1'b0;
    ld(1'b0, 16'hdead);
    chk("acc", acc_out, 16'h0030);
    ce_in = 1'b1;
    // second reset in mid-run
    nrst_in = 1'b0;
    @(negedge ref_clk_in);
    nrst_in = 1'b1;
    chk("iptr", iptr_out, 16'hfffd);
    chk("status", status_out, 16'h0030);
    finish_test();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    finish_test();
  end
endmodule
